//--- rtl/anps_apb_decode.sv
// module: apb address decode and strobes for the partner status block
`timescale 1ns/1ns
module anps_apb_decode
(
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             rd_strobe,
  output logic             wr_strobe,
  output logic             hit_ability,
  output logic             hit_expansion,
  output logic             hit_status,
  output logic             hit_mask,
  output logic             unmapped
);

  //==========================================================================
  // decode
  //==========================================================================
  wire access_phase = psel & penable;

  assign rd_strobe     = access_phase & ~pwrite;
  assign wr_strobe     = access_phase &  pwrite;
  assign hit_ability   = (paddr == anps_pkg::PARTNER_ABILITY_ADDR);
  assign hit_expansion = (paddr == anps_pkg::AUTONEG_EXPANSION_ADDR);
  assign hit_status    = (paddr == anps_pkg::IRQ_STATUS_ADDR);
  assign hit_mask      = (paddr == anps_pkg::IRQ_MASK_ADDR);
  assign unmapped      = ~(hit_ability | hit_expansion | hit_status | hit_mask);

endmodule : anps_apb_decode

//--- rtl/anps_partner_status.sv
// module: link partner ability and auto-negotiation expansion status registers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
// Operation
// - partner ability captured from received bursts
// - bit 15 shows partner next page
// - acknowledge bit from bursts, writes ignored
// - bit 13 shows partner remote fault
// - reserved bits read zero, writes ignored
// - bit 10 shows partner flow control
// - bits 9..5 show partner technologies
// - bits 4..0 selector, zero after reset
// - parallel detection fault latches high
// - expansion bit 3 partner next page able
// - local next page able reads zero
// - expansion bit 0 partner autoneg able
module anps_partner_status
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        page_valid,
  input  wire logic [15:0] page_word,
  input  wire logic        parallel_fault,
  input  wire logic        partner_an_detected,
  output logic             irq
);

  //==========================================================================
  // decode
  //==========================================================================
  logic rd_strobe;
  logic wr_strobe;
  logic hit_ability;
  logic hit_expansion;
  logic hit_status;
  logic hit_mask;
  logic unmapped;

  anps_apb_decode u_decode
  (
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .rd_strobe     (rd_strobe),
    .wr_strobe     (wr_strobe),
    .hit_ability   (hit_ability),
    .hit_expansion (hit_expansion),
    .hit_status    (hit_status),
    .hit_mask      (hit_mask),
    .unmapped      (unmapped)
  );

  //==========================================================================
  // state
  //==========================================================================
  logic [15:0] partner_ability_q;
  logic [15:0] partner_ability_d;
  logic        parallel_detect_fault_q;
  logic        parallel_detect_fault_d;
  logic        page_received_q;
  logic        page_received_d;
  logic        partner_autoneg_capable_q;
  logic        partner_autoneg_capable_d;
  logic [anps_pkg::IRQ_WIDTH-1:0] irq_status_q;
  logic [anps_pkg::IRQ_WIDTH-1:0] irq_status_d;
  logic [anps_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic [anps_pkg::IRQ_WIDTH-1:0] irq_mask_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        access_q;
  logic        fault_rise;
  logic        fault_prev_q;

  wire read_expansion = rd_strobe & hit_expansion & ~access_q;
  wire first_access   = psel & penable & ~access_q;

  //==========================================================================
  // partner ability capture
  //==========================================================================
  // whole page word is taken; reserved bits forced to zero
  assign partner_ability_d = page_valid
                           ? (page_word & anps_pkg::ABILITY_WRITABLE_MASK)
                           : partner_ability_q;

  //==========================================================================
  // expansion flags
  //==========================================================================
  // set wins over the read-clear for both latched bits
  assign parallel_detect_fault_d = parallel_fault
                                 | (parallel_detect_fault_q & ~read_expansion);
  assign page_received_d         = page_valid
                                 | (page_received_q & ~read_expansion);
  assign partner_autoneg_capable_d = partner_autoneg_capable_q
                                   | partner_an_detected | page_valid;

  //==========================================================================
  // interrupts
  //==========================================================================
  assign fault_rise = parallel_fault & ~fault_prev_q;

  wire status_write = first_access & pwrite & hit_status;
  wire mask_write   = first_access & pwrite & hit_mask;

  logic [anps_pkg::IRQ_WIDTH-1:0] irq_events;
  assign irq_events[anps_pkg::IRQ_PAGE_BIT]  = page_valid;
  assign irq_events[anps_pkg::IRQ_FAULT_BIT] = fault_rise;

  assign irq_status_d = irq_events
                      | (irq_status_q
                         & ~(status_write ? pwdata[anps_pkg::IRQ_WIDTH-1:0]
                                          : {anps_pkg::IRQ_WIDTH{1'b0}}));
  assign irq_mask_d   = mask_write ? pwdata[anps_pkg::IRQ_WIDTH-1:0] : irq_mask_q;
  assign irq          = |(irq_status_q & irq_mask_q);

  //==========================================================================
  // read mux
  //==========================================================================
  wire [10:0] expansion_reserved        = 11'h000;
  wire        partner_next_page_capable = partner_ability_q[anps_pkg::NEXT_PAGE_FLAG_BIT];
  wire        local_next_page_capable   = anps_pkg::LOCAL_NP_VALUE;

  wire [15:0] expansion_view =
    {expansion_reserved,
     parallel_detect_fault_q,
     partner_next_page_capable,
     local_next_page_capable,
     page_received_q,
     partner_autoneg_capable_q};

  // field view of the stored partner page
  wire       next_page_flag        = partner_ability_q[anps_pkg::NEXT_PAGE_FLAG_BIT];
  wire       partner_ack           = partner_ability_q[anps_pkg::PARTNER_ACK_BIT];
  wire       remote_fault          = partner_ability_q[anps_pkg::REMOTE_FAULT_BIT];
  wire [1:0] ability_reserved      = 2'h0;
  wire       flow_control_support  = partner_ability_q[anps_pkg::FLOW_CONTROL_BIT];
  wire       four_pair_able        = partner_ability_q[anps_pkg::TECH_MSB];
  wire       fast_full_duplex_able = partner_ability_q[anps_pkg::TECH_MSB - 1];
  wire       fast_half_duplex_able = partner_ability_q[anps_pkg::TECH_MSB - 2];
  wire       slow_full_duplex_able = partner_ability_q[anps_pkg::TECH_MSB - 3];
  wire       slow_half_duplex_able = partner_ability_q[anps_pkg::TECH_LSB];
  wire [4:0] protocol_selector     = partner_ability_q[anps_pkg::SELECTOR_MSB:0];

  wire [15:0] ability_view =
    {next_page_flag,
     partner_ack,
     remote_fault,
     ability_reserved,
     flow_control_support,
     four_pair_able,
     fast_full_duplex_able,
     fast_half_duplex_able,
     slow_full_duplex_able,
     slow_half_duplex_able,
     protocol_selector};

  assign prdata_d = ~(rd_strobe & ~access_q) ? prdata_q
                  : hit_ability   ? {16'h0000, ability_view}
                  : hit_expansion ? {16'h0000, expansion_view}
                  : hit_status    ? {{(32-anps_pkg::IRQ_WIDTH){1'b0}}, irq_status_q}
                  : hit_mask      ? {{(32-anps_pkg::IRQ_WIDTH){1'b0}}, irq_mask_q}
                  : 32'h00000000;

  // writes to read-only registers are dropped silently; unmapped access errors
  assign pslverr_d = first_access ? unmapped : 1'b0;

  assign pready  = access_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  //==========================================================================
  // registers
  //==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      partner_ability_q <= anps_pkg::PARTNER_ABILITY_RESET;
    end
    else
    begin
      partner_ability_q <= partner_ability_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parallel_detect_fault_q <= 1'b0;
    end
    else
    begin
      parallel_detect_fault_q <= parallel_detect_fault_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_received_q <= 1'b0;
    end
    else
    begin
      page_received_q <= page_received_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      partner_autoneg_capable_q <= 1'b0;
    end
    else
    begin
      partner_autoneg_capable_q <= partner_autoneg_capable_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_q <= '0;
    end
    else
    begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_q <= '0;
    end
    else
    begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // response flops: one wait state, read data held until the next read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h00000000;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_q <= 1'b0;
    end
    else
    begin
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      access_q <= 1'b0;
    end
    else
    begin
      access_q <= first_access;
    end
  end

  // previous fault level, for the rising-edge interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_prev_q <= 1'b0;
    end
    else
    begin
      fault_prev_q <= parallel_fault;
    end
  end

endmodule : anps_partner_status

//--- rtl/anps_pkg.sv
// package: register map, field positions and reset values of the partner status block
package anps_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0]  PARTNER_ABILITY_IDX   = 8'h05;
  localparam logic [7:0]  AUTONEG_EXPANSION_IDX = 8'h06;
  localparam logic [7:0]  IRQ_STATUS_IDX        = 8'h10;
  localparam logic [7:0]  IRQ_MASK_IDX          = 8'h11;

  localparam logic [11:0] PARTNER_ABILITY_ADDR   = 12'h014;
  localparam logic [11:0] AUTONEG_EXPANSION_ADDR = 12'h018;
  localparam logic [11:0] IRQ_STATUS_ADDR        = 12'h040;
  localparam logic [11:0] IRQ_MASK_ADDR          = 12'h044;

  // partner_ability fields
  localparam int NEXT_PAGE_FLAG_BIT   = 15;
  localparam int PARTNER_ACK_BIT      = 14;
  localparam int REMOTE_FAULT_BIT     = 13;
  localparam int FLOW_CONTROL_BIT     = 10;
  localparam int TECH_MSB             = 9;
  localparam int TECH_LSB             = 5;
  localparam int SELECTOR_MSB         = 4;

  // autoneg_expansion fields
  localparam int PARALLEL_FAULT_BIT   = 4;
  localparam int PARTNER_NP_BIT       = 3;
  localparam int LOCAL_NP_BIT         = 2;
  localparam int PAGE_RECEIVED_BIT    = 1;
  localparam int PARTNER_AN_BIT       = 0;

  // interrupt status / mask layout
  localparam int IRQ_PAGE_BIT         = 0;
  localparam int IRQ_FAULT_BIT        = 1;
  localparam int IRQ_WIDTH            = 2;

  localparam logic [15:0] PARTNER_ABILITY_RESET = 16'h0000;
  localparam logic [15:0] ABILITY_WRITABLE_MASK = 16'hE7FF;
  localparam logic [4:0]  SELECTOR_RESET        = 5'h00;
  localparam logic        LOCAL_NP_VALUE        = 1'b0;

endpackage : anps_pkg

//--- test/anps_apb_mst.sv
// model: management-side apb master issuing register transfers
`timescale 1ns/1ns
module anps_apb_mst
(
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic      [11:0] paddr = 12'h000,
  output logic      [31:0] pwdata = 32'h0
);
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : anps_apb_mst

//--- test/anps_checker.sv
// checker: port assertions for the partner status block
`timescale 1ns/1ns
module anps_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        page_valid,
  input wire logic [15:0] page_word,
  input wire logic        parallel_fault,
  input wire logic        partner_an_detected,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // model of the last page word and of the pending new-page flag
  logic [15:0] last_word_q;
  logic        page_seen_q;
  wire rd   = psel && pready && !pwrite;
  wire rd_a = rd && paddr == anps_pkg::PARTNER_ABILITY_ADDR;
  wire rd_e = rd && paddr == anps_pkg::AUTONEG_EXPANSION_ADDR;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_word_q <= 16'h0000;
      page_seen_q <= 1'b0;
    end
    else
    begin
      if (page_valid)
        last_word_q <= page_word;
      page_seen_q <= page_valid | (page_seen_q & ~rd_e);
    end
  end
  property p_hi; rd_a && !$past(page_valid) |-> prdata[15:13] == last_word_q[15:13]; endproperty
  a_hi: assert property (p_hi) else $error("ability high bits wrong");
  property p_lo; rd_a && !$past(page_valid) |-> prdata[10:0] == last_word_q[10:0]; endproperty
  a_lo: assert property (p_lo) else $error("ability low bits wrong");
  property p_rsa; rd_a |-> (prdata & 32'hFFFF1800) == 32'h0; endproperty
  a_rsa: assert property (p_rsa) else $error("ability reserved set");
  property p_rse; rd_e |-> prdata[31:5] == 27'h0; endproperty
  a_rse: assert property (p_rse) else $error("expansion reserved set");
  property p_lnp; rd_e |-> !prdata[2]; endproperty
  a_lnp: assert property (p_lnp) else $error("local next page set");
  property p_pdf; rd_e && $past(parallel_fault, 2) |-> prdata[4]; endproperty
  a_pdf: assert property (p_pdf) else $error("fault not latched");
  property p_pnp; rd_e && !$past(page_valid) |-> prdata[3] == last_word_q[15]; endproperty
  a_pnp: assert property (p_pnp) else $error("partner next page wrong");
  property p_prx; rd_e && page_seen_q && !$past(page_valid) |-> prdata[1] && prdata[0]; endproperty
  a_prx: assert property (p_prx) else $error("page flags missing");
endmodule : anps_checker
bind anps_partner_status anps_checker i_chk
(
  .pclk                (pclk),
  .presetn             (presetn),
  .psel                (psel),
  .penable             (penable),
  .pwrite              (pwrite),
  .paddr               (paddr),
  .pwdata              (pwdata),
  .prdata              (prdata),
  .pready              (pready),
  .pslverr             (pslverr),
  .page_valid          (page_valid),
  .page_word           (page_word),
  .parallel_fault      (parallel_fault),
  .partner_an_detected (partner_an_detected),
  .irq                 (irq)
);

//--- test/tb_top.sv
// testbench: reads, events and interrupts of the partner status block
`timescale 1ns/1ns
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, page_valid = 1'b0;
  logic        parallel_fault = 1'b0, partner_an_detected = 1'b0;
  logic [15:0] page_word = 16'h0000;
  logic        psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q_rd;
  int          fails = 0;
  int          n_tests = 0;
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  anps_partner_status i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .page_valid(page_valid), .page_word(page_word), .irq(irq),
    .parallel_fault(parallel_fault), .partner_an_detected(partner_an_detected));
  anps_apb_mst i_mst (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ==========
  // helpers
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task rd(input logic [11:0] a, input logic [31:0] e);
    i_mst.xfer(1'b0, a, 32'h0, q_rd, err);
    cmp($sformatf("reg %h", a), e, q_rd);
  endtask : rd
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_mst.xfer(1'b1, a, d, q_rd, err);
  endtask : wr
  task pg(input logic [15:0] w);
    @(posedge pclk);
    page_valid <= 1'b1;
    page_word  <= w;
    @(posedge pclk);
    page_valid <= 1'b0;
    page_word  <= ~w;
  endtask : pg
  // ==========
  // scenarios
  task s_reset;
    rd(12'h014, 32'h0);
    rd(12'h018, 32'h0);
    @(posedge pclk);
    partner_an_detected <= 1'b1;
    @(posedge pclk);
    partner_an_detected <= 1'b0;
    rd(12'h018, 32'h1);
  endtask : s_reset
  task s_page;
    pg(16'hFFFF);
    rd(12'h014, 32'hE7FF);
    rd(12'h018, 32'hB);
    rd(12'h018, 32'h9);
    wr(12'h014, 32'hFFFFFFFF);
    wr(12'h018, 32'hFFFFFFFF);
    rd(12'h014, 32'hE7FF);
    pg(16'h0421);
    rd(12'h014, 32'h0421);
    rd(12'h018, 32'h3);
  endtask : s_page
  task s_fault;
    @(posedge pclk);
    parallel_fault <= 1'b1;
    @(posedge pclk);
    parallel_fault <= 1'b0;
    rd(12'h018, 32'h11);
    rd(12'h018, 32'h1);
    parallel_fault <= 1'b1;
    rd(12'h018, 32'h11);
    parallel_fault <= 1'b0;
    rd(12'h018, 32'h11);
    rd(12'h018, 32'h1);
  endtask : s_fault
  task s_irq;
    wr(12'h040, 32'h3);
    rd(12'h040, 32'h0);
    wr(12'h044, 32'h3);
    rd(12'h044, 32'h3);
    pg(16'h0001);
    rd(12'h040, 32'h1);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(12'h040, 32'h1);
    rd(12'h040, 32'h0);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(12'h044, 32'h0);
    pg(16'h0001);
    rd(12'h040, 32'h1);
    cmp("irq", 32'h0, {31'h0, irq});
    rd(12'h100, 32'h0);
    cmp("slverr", 32'h1, {31'h0, err});
  endtask : s_irq
  task stop_test;
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_page;
    s_fault;
    s_irq;
    stop_test;
  end
  initial
  begin
    #20000;
    fails++;
    stop_test;
  end
endmodule : tb_top
